// ===== fepcs_pkg.sv
// Shared constants, code-group table and carrier types for the line coding.
// Overview of operation
// - Invalid code-groups raise receive error during data valid.
// - Scrambler scrambles and serialises each code-group.
// - Serial scrambled bits become 125 MHz NRZI.
// - MLT-3 steps level on one, holds on zero.
// - Received MLT-3 levels convert back to NRZI bits.
// - Descrambler inverts scrambling and parallelises the stream.
// - Key synchronises on idles, then stays locked until an idle window expires.
// - No idle within 40 us aborts and resyncs, except in bypass.
// - Bypass input skips the descrambler entirely.
// - J/K delimiter sets the code-group boundary.
// - Boundary kept until the next start delimiter.
// - Start delimiter delivered as nibbles 0101 0101.
// - Start delimiter asserts receive data valid.
// - Each valid code-group decodes to one nibble.
// - T/R or two idles drop carrier and valid.
// - End delimiter and idles never reach the MAC.
package fepcs_pkg;

  localparam int CLK_MHZ        = 125;
  localparam int IDLE_WINDOW_US = 40;
  localparam int IDLE_WINDOW_CYC = IDLE_WINDOW_US * CLK_MHZ;
  localparam int WIN_W          = 13;

  localparam int GROUP_BITS     = 5;
  localparam logic [2:0] LAST_PHASE = 3'h4;
  localparam logic [2:0] CLK_HIGH_PHASES = 3'h2;

  localparam int KEY_W          = 11;
  localparam int KEY_TAP_A      = 10;
  localparam int KEY_TAP_B      = 8;
  localparam logic [10:0] KEY_SEED = 11'h7FF;
  localparam logic [5:0] LOCK_MATCHES = 6'h20;
  localparam logic [3:0] IDLE_RUN_BITS = 4'hA;

  localparam logic [4:0] CG_IDLE = 5'h1F;
  localparam logic [4:0] CG_J    = 5'h18;
  localparam logic [4:0] CG_K    = 5'h11;
  localparam logic [4:0] CG_T    = 5'h0D;
  localparam logic [4:0] CG_R    = 5'h07;
  localparam logic [4:0] CG_INV3 = 5'h03;
  localparam logic [4:0] CG_INV5 = 5'h05;
  localparam logic [4:0] CG_INV8 = 5'h08;
  localparam logic [4:0] CG_INVC = 5'h0C;
  localparam logic [4:0] CG_INV10 = 5'h10;
  localparam logic [3:0] SSD_NIBBLE = 4'h5;

  typedef struct packed {
    logic pos;
    logic neg;
  } fepcs_mlt_t;

  typedef struct packed {
    logic       dv;
    logic       er;
    logic       crs;
    logic [3:0] nibble;
  } fepcs_mii_rx_t;

  typedef struct packed {
    logic       ok;
    logic [3:0] nibble;
  } fepcs_dec_t;

  typedef enum logic [2:0] {
    ST_HUNT   = 3'h1,
    ST_SECOND = 3'h2,
    ST_DATA   = 3'h4
  } fepcs_rxst_t;

  // Data code-group to nibble; control and invalid groups report not ok.
  function automatic fepcs_dec_t fepcs_decode(input logic [4:0] cg);
    fepcs_dec_t d;
    d = '{ok: 1'b1, nibble: 4'h0};
    case (cg)
      5'h1E: d.nibble = 4'h0;
      5'h09: d.nibble = 4'h1;
      5'h14: d.nibble = 4'h2;
      5'h15: d.nibble = 4'h3;
      5'h0A: d.nibble = 4'h4;
      5'h0B: d.nibble = 4'h5;
      5'h0E: d.nibble = 4'h6;
      5'h0F: d.nibble = 4'h7;
      5'h12: d.nibble = 4'h8;
      5'h13: d.nibble = 4'h9;
      5'h16: d.nibble = 4'hA;
      5'h17: d.nibble = 4'hB;
      5'h1A: d.nibble = 4'hC;
      5'h1B: d.nibble = 4'hD;
      5'h1C: d.nibble = 4'hE;
      5'h1D: d.nibble = 4'hF;
      default: d.ok = 1'b0;
    endcase
    return d;
  endfunction

endpackage

// ===== fepcs_line_coding.sv
// Transmit scrambling and MLT-3 encoding, receive decoding toward the MII.
`timescale 1ns/1ns
`default_nettype none
module fepcs_line_coding #(
  parameter int IDLE_WINDOW = fepcs_pkg::IDLE_WINDOW_CYC
) (
  input  wire logic                     core_clk,     // 125 MHz bit clock
  input  wire logic                     sys_rst,      // Sync reset, high
  input  wire logic [4:0]               txCodeGroup,  // Next code-group
  output logic                          txGroupTake,  // Group taken now
  output fepcs_pkg::fepcs_mlt_t         txMlt,        // Line level out
  input  wire fepcs_pkg::fepcs_mlt_t    rxMlt,        // Recovered level
  input  wire logic                     descrBypass,  // Skip descrambler
  output fepcs_pkg::fepcs_mii_rx_t      rxMii,        // Nibble toward MAC
  output logic                          rxNibbleClk,  // 25 MHz receive clock
  output logic                          rxLocked      // Key is locked
);

  typedef struct packed {
    logic [2:0]              txPhase;
    logic [4:0]              txShift;
    logic [10:0]             txKey;
    logic                    txNrzi;
    fepcs_pkg::fepcs_mlt_t   txLevel;
    logic                    txLastPos;
    fepcs_pkg::fepcs_mlt_t   rxPrev;
    logic [10:0]             rxKey;
    logic                    locked;
    logic [5:0]              matchCnt;
    logic [3:0]              onesRun;
    logic [12:0]             winCnt;
    logic [9:0]              rxShift;
    logic [2:0]              rxPhase;
    logic [4:0]              hold;
    fepcs_pkg::fepcs_rxst_t  st;
    fepcs_pkg::fepcs_mii_rx_t mii;
  } fepcs_state_t;

  fepcs_state_t s_r;
  fepcs_state_t s_nxt;

  function automatic logic keyBit(input logic [10:0] k);
    return k[fepcs_pkg::KEY_TAP_A] ^ k[fepcs_pkg::KEY_TAP_B];
  endfunction

  function automatic fepcs_pkg::fepcs_mlt_t zeroLevel();
    return '{pos: 1'b0, neg: 1'b0};
  endfunction

  logic                   txBit;
  logic                   txScr;
  logic                   rxCodeBit;
  logic                   rxPlain;
  logic [9:0]             shiftNow;
  logic [4:0]             groupNow;
  fepcs_pkg::fepcs_dec_t  holdDec;
  logic                   boundary;
  logic                   ssdSeen;
  logic                   idleEnd;
  logic                   badGroup;

  assign txGroupTake = (s_r.txPhase == fepcs_pkg::LAST_PHASE);
  assign txMlt       = s_r.txLevel;
  assign rxMii       = s_r.mii;
  assign rxLocked    = s_r.locked;
  assign rxNibbleClk = (s_r.rxPhase < fepcs_pkg::CLK_HIGH_PHASES);

  always_comb begin
    s_nxt = s_r;

    // Transmit: one code bit per clock, five per group.
    txBit = s_r.txShift[fepcs_pkg::GROUP_BITS - 1];
    txScr = txBit ^ keyBit(s_r.txKey);
    s_nxt.txKey = {s_r.txKey[9:0], keyBit(s_r.txKey)};
    if (txGroupTake) begin
      s_nxt.txPhase = 3'h0;
      s_nxt.txShift = txCodeGroup;
    end else begin
      s_nxt.txPhase = s_r.txPhase + 3'h1;
      s_nxt.txShift = {s_r.txShift[3:0], 1'b0};
    end
    s_nxt.txNrzi = s_r.txNrzi ^ txScr;
    // A transition in NRZI moves MLT-3 one step around 0,+,0,-.
    if (s_nxt.txNrzi != s_r.txNrzi) begin
      if (s_r.txLevel.pos || s_r.txLevel.neg) begin
        s_nxt.txLevel   = zeroLevel();
        s_nxt.txLastPos = s_r.txLevel.pos;
      end else begin
        s_nxt.txLevel = '{pos: ~s_r.txLastPos, neg: s_r.txLastPos};
      end
    end

    // Receive: a level change is a code bit of one.
    s_nxt.rxPrev = rxMlt;
    rxCodeBit = (rxMlt != s_r.rxPrev);

    // Idle plaintext is all ones, so the key bit is the inverted line bit.
    if (descrBypass) begin
      rxPlain = rxCodeBit;
      s_nxt.locked   = 1'b1;
      s_nxt.matchCnt = 6'h0;
    end else if (s_r.locked) begin
      rxPlain = rxCodeBit ^ keyBit(s_r.rxKey);
      s_nxt.rxKey = {s_r.rxKey[9:0], keyBit(s_r.rxKey)};
    end else begin
      rxPlain = 1'b0;
      s_nxt.rxKey = {s_r.rxKey[9:0], ~rxCodeBit};
      if (keyBit(s_r.rxKey) == ~rxCodeBit) begin
        s_nxt.matchCnt = s_r.matchCnt + 6'h1;
      end else begin
        s_nxt.matchCnt = 6'h0;
      end
      if (s_r.matchCnt == fepcs_pkg::LOCK_MATCHES) begin
        s_nxt.locked   = 1'b1;
        s_nxt.matchCnt = 6'h0;
      end
    end

    // Ten plain ones in a row are two idle code-groups.
    if (!s_r.locked) begin
      s_nxt.onesRun = 4'h0;
    end else if (!rxPlain) begin
      s_nxt.onesRun = 4'h0;
    end else if (s_r.onesRun != fepcs_pkg::IDLE_RUN_BITS) begin
      s_nxt.onesRun = s_r.onesRun + 4'h1;
    end
    idleEnd = s_r.locked && rxPlain &&
              (s_r.onesRun == fepcs_pkg::IDLE_RUN_BITS - 4'h1);

    shiftNow = {s_r.rxShift[8:0], rxPlain};
    s_nxt.rxShift = shiftNow;
    groupNow = shiftNow[4:0];
    holdDec  = fepcs_pkg::fepcs_decode(s_r.hold);
    boundary = (s_r.rxPhase == fepcs_pkg::LAST_PHASE);
    ssdSeen  = s_r.locked &&
               (shiftNow == {fepcs_pkg::CG_J, fepcs_pkg::CG_K});
    badGroup = (s_r.hold == fepcs_pkg::CG_INV3) ||
               (s_r.hold == fepcs_pkg::CG_INV5) ||
               (s_r.hold == fepcs_pkg::CG_INV8) ||
               (s_r.hold == fepcs_pkg::CG_INVC) ||
               (s_r.hold == fepcs_pkg::CG_INV10) || !holdDec.ok;

    s_nxt.rxPhase = boundary ? 3'h0 : s_r.rxPhase + 3'h1;

    // Missing idles for a whole window abort the frame and the lock.
    // A continuing idle run keeps restarting the window, not only its start.
    if (!s_r.locked || descrBypass || idleEnd ||
        s_r.onesRun == fepcs_pkg::IDLE_RUN_BITS) begin
      s_nxt.winCnt = 13'h0;
    end else if (s_r.winCnt ==
                 fepcs_pkg::WIN_W'(IDLE_WINDOW - 1)) begin
      s_nxt.winCnt   = 13'h0;
      s_nxt.locked   = 1'b0;
      s_nxt.matchCnt = 6'h0;
      s_nxt.st       = fepcs_pkg::ST_HUNT;
      s_nxt.mii.dv   = 1'b0;
      s_nxt.mii.crs  = 1'b0;
      s_nxt.mii.er   = 1'b0;
    end else begin
      s_nxt.winCnt = s_r.winCnt + 13'h1;
    end

    if (ssdSeen) begin
      // New boundary; the J nibble goes out at once, K follows.
      s_nxt.rxPhase    = 3'h0;
      s_nxt.st         = fepcs_pkg::ST_SECOND;
      s_nxt.mii.dv     = 1'b1;
      s_nxt.mii.crs    = 1'b1;
      s_nxt.mii.er     = 1'b0;
      s_nxt.mii.nibble = fepcs_pkg::SSD_NIBBLE;
    end else if (boundary && s_r.locked) begin
      unique case (s_r.st)
        fepcs_pkg::ST_HUNT: begin
          s_nxt.mii.dv  = 1'b0;
          s_nxt.mii.crs = 1'b0;
          s_nxt.mii.er  = 1'b0;
        end
        fepcs_pkg::ST_SECOND: begin
          s_nxt.mii.nibble = fepcs_pkg::SSD_NIBBLE;
          s_nxt.hold       = groupNow;
          s_nxt.st         = fepcs_pkg::ST_DATA;
        end
        fepcs_pkg::ST_DATA: begin
          // One group of delay lets T/R and idles end the frame unseen.
          s_nxt.hold = groupNow;
          if ((s_r.hold == fepcs_pkg::CG_T && groupNow == fepcs_pkg::CG_R) ||
              (s_r.hold == fepcs_pkg::CG_IDLE &&
               groupNow == fepcs_pkg::CG_IDLE)) begin
            s_nxt.st      = fepcs_pkg::ST_HUNT;
            s_nxt.mii.dv  = 1'b0;
            s_nxt.mii.crs = 1'b0;
            s_nxt.mii.er  = 1'b0;
          end else begin
            s_nxt.mii.nibble = holdDec.nibble;
            s_nxt.mii.er     = badGroup;
          end
        end
        default: begin
          s_nxt.st = fepcs_pkg::ST_HUNT;
        end
      endcase
    end else if (idleEnd && s_r.st != fepcs_pkg::ST_HUNT) begin
      s_nxt.st      = fepcs_pkg::ST_HUNT;
      s_nxt.mii.dv  = 1'b0;
      s_nxt.mii.crs = 1'b0;
      s_nxt.mii.er  = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_r           <= '0;
      s_r.txKey     <= fepcs_pkg::KEY_SEED;
      s_r.rxKey     <= fepcs_pkg::KEY_SEED;
      s_r.st        <= fepcs_pkg::ST_HUNT;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule
`default_nettype wire

// ===== fepcs_checker.sv
// Port assertions for the line coding block.
`timescale 1ns/1ns
`default_nettype none
module fepcs_checker (
  input wire logic                     core_clk,    // Clock
  input wire logic                     sys_rst,     // Reset
  input wire logic                     txGroupTake, // Take
  input wire fepcs_pkg::fepcs_mlt_t    txMlt,       // Line out
  input wire logic                     descrBypass, // Bypass
  input wire fepcs_pkg::fepcs_mii_rx_t rxMii,       // MII out
  input wire logic                     rxNibbleClk, // Receive clock
  input wire logic                     rxLocked     // Lock
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence s_take_gap;
    !txGroupTake [*4] ##1 txGroupTake;
  endsequence
  sequence s_ssd_hold;
    (rxMii.nibble == fepcs_pkg::SSD_NIBBLE) [*8];
  endsequence
  a_mlt_legal: assert property (txMlt != 2'h3)
    else $error("both levels driven");
  a_mlt_step: assert property (txMlt != 2'h0 |=>
    txMlt == $past(txMlt) || txMlt == 2'h0) else $error("level skip");
  a_take_gap: assert property (txGroupTake |=> s_take_gap)
    else $error("take spacing");
  a_bypass_lock: assert property (descrBypass [*2] |-> rxLocked)
    else $error("bypass lock");
  a_dv_crs: assert property (rxMii.dv |-> rxMii.crs)
    else $error("valid without carrier");
  a_er_frame: assert property (rxMii.er |-> rxMii.dv)
    else $error("error outside frame");
  a_unlock_quiet: assert property (
    !rxLocked && !$past(rxLocked) |-> !rxMii.dv) else $error("valid unlocked");
  a_ssd_first: assert property ($rose(rxMii.dv) |-> s_ssd_hold)
    else $error("preamble nibbles");
  a_nib_clk: assert property (rxMii.dv && $past(rxMii.dv) &&
    $changed(rxMii.nibble) |-> rxNibbleClk) else $error("nibble off clock");
endmodule
`default_nettype wire

// ===== fepcs_link_partner.sv
// Remote transmitter model: scrambles groups and drives MLT-3 levels.
`timescale 1ns/1ns
`default_nettype none
module fepcs_link_partner (
  input  wire logic             clk,   // Line clock
  input  wire logic [4:0]       grp,   // Group for the next take
  input  wire logic             scrOn, // Scrambling on
  output logic                  take,  // Group taken at this edge
  output fepcs_pkg::fepcs_mlt_t mlt    // Line level
);
  logic [2:0]  ph = 3'h0;
  logic [4:0]  sh = 5'h1F;
  logic [10:0] key = 11'h123;
  logic        lastPos = 1'b0;
  logic        lineBit;
  assign take = (ph == 3'h4);
  assign lineBit = sh[4] ^ (scrOn & (key[10] ^ key[8]));
  initial mlt = 2'h0;
  always @(posedge clk) begin
    ph <= take ? 3'h0 : ph + 3'h1;
    sh <= take ? grp : {sh[3:0], 1'b0};
    key <= {key[9:0], key[10] ^ key[8]};
    if (lineBit && mlt != 2'h0)
      mlt <= 2'h0;
    else if (lineBit) begin
      mlt <= lastPos ? 2'h1 : 2'h2;
      lastPos <= !lastPos;
    end
  end
endmodule
`default_nettype wire

// ===== fepcs_line_coding_tb.sv
// Self-checking bench for the line coding block.
`timescale 1ns/1ns
`default_nettype none
module fepcs_line_coding_tb;
  logic                     core_clk, sys_rst, descrBypass, pScr, pTake;
  logic                     txGroupTake, rxNibbleClk, rxLocked, sawEr, sawUn;
  logic [4:0]               txCodeGroup, pGrp, enc[16], inv[5];
  fepcs_pkg::fepcs_mlt_t    txMlt, rxMlt;
  fepcs_pkg::fepcs_mii_rx_t rxMii;
  logic [3:0]               got[$];
  int                       ph5 = 0, error_cnt = 0, n_compared = 0;
  fepcs_line_coding #(.IDLE_WINDOW(200)) uut (.core_clk(core_clk),
    .sys_rst(sys_rst), .txCodeGroup(txCodeGroup),
    .txGroupTake(txGroupTake), .txMlt(txMlt), .rxMlt(rxMlt),
    .descrBypass(descrBypass), .rxMii(rxMii), .rxNibbleClk(rxNibbleClk),
    .rxLocked(rxLocked));
  fepcs_link_partner peer (.clk(core_clk), .grp(pGrp), .scrOn(pScr),
    .take(pTake), .mlt(rxMlt));
  // Samples each nibble mid-slot; slots start at the rise of valid.
  always @(posedge core_clk) begin
    ph5 <= (!rxMii.dv || ph5 == 4) ? 0 : ph5 + 1;
    if (rxMii.dv && ph5 == 2)
      got.push_back(rxMii.nibble);
    if (rxMii.er)
      sawEr <= 1'b1;
    if (!rxLocked)
      sawUn <= 1'b1;
  end
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("%0d compared, %0d mismatched", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic send(logic [4:0] g);
    @(posedge core_clk iff pTake);
    pGrp <= g;
  endtask
  task automatic frame(logic [4:0] bad, logic useEnd, int len);
    got.delete();
    sawEr = 1'b0;
    sawUn = 1'b0;
    send(fepcs_pkg::CG_J);
    send(fepcs_pkg::CG_K);
    for (int i = 0; i < len; i++)
      send((i == 8 && bad != 5'h00) ? bad : enc[i % 16]);
    if (useEnd) begin
      send(fepcs_pkg::CG_T);
      send(fepcs_pkg::CG_R);
    end
    repeat (30) send(fepcs_pkg::CG_IDLE);
    @(negedge core_clk);
  endtask
  task automatic t_tx();
    fepcs_pkg::fepcs_mlt_t last;
    logic [10:0]           hist;
    logic [4:0]            sh;
    logic                  b, p, k, tk;
    last = txMlt;
    hist = 11'h000;
    sh = 5'h00;
    p = 1'b0;
    // Mirrors the group shifter so every line bit has a known plain bit.
    for (int i = 0; i < 80; i++) begin
      @(negedge core_clk);
      b = (txMlt != last);
      last = txMlt;
      k = hist[10] ^ hist[8];
      if (i > 12)
        check("tx bit", {7'h0, b}, {7'h0, p ^ k});
      hist = {hist[9:0], b ^ p};
      p = sh[4];
      tk = txGroupTake;
      sh = tk ? txCodeGroup : {sh[3:0], 1'b0};
      @(posedge core_clk);
      if (tk)
        txCodeGroup <= enc[i % 16];
    end
    $display("tx test done");
  endtask
  task automatic t_good(logic byp);
    send(fepcs_pkg::CG_IDLE);
    descrBypass <= byp;
    pScr <= !byp;
    repeat (40) send(fepcs_pkg::CG_IDLE);
    frame(5'h00, 1'b1, 16);
    check("count", 8'(got.size()), 8'h12);
    foreach (got[i])
      check("nibble", {4'h0, got[i]}, i < 2 ? 8'h05 : 8'(i - 2));
    check("error", {7'h0, sawEr}, 8'h00);
    check("unlock", {7'h0, sawUn}, 8'h00);
    check("crs dv", {6'h0, rxMii.crs, rxMii.dv}, 8'h00);
    $display("frame test done, bypass %0d", byp);
  endtask
  task automatic t_bad();
    foreach (inv[j]) begin
      frame(inv[j], 1'b0, 16);
      check("error", {7'h0, sawEr}, 8'h01);
      check("valid", {7'h0, rxMii.dv}, 8'h00);
    end
    $display("invalid group test done");
  endtask
  task automatic t_window();
    frame(5'h00, 1'b0, 50);
    check("unlock", {7'h0, sawUn}, 8'h01);
    check("dropped", {7'h0, got.size() < 52}, 8'h01);
    check("relock", {7'h0, rxLocked}, 8'h01);
    $display("idle window test done");
  endtask
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    repeat (30000) @(posedge core_clk);
    error_cnt++;
    give_verdict();
  end
  initial begin
    sys_rst = 1'b1;
    descrBypass = 1'b0;
    pScr = 1'b1;
    pGrp = fepcs_pkg::CG_IDLE;
    txCodeGroup = fepcs_pkg::CG_IDLE;
    enc = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
            5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
    inv = '{5'h03, 5'h05, 5'h08, 5'h0C, 5'h10};
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_tx();
    t_good(1'b0);
    t_bad();
    t_window();
    t_good(1'b1);
    give_verdict();
  end
endmodule
bind fepcs_line_coding fepcs_checker chk (.core_clk(core_clk),
  .sys_rst(sys_rst), .txGroupTake(txGroupTake), .txMlt(txMlt),
  .descrBypass(descrBypass), .rxMii(rxMii), .rxNibbleClk(rxNibbleClk),
  .rxLocked(rxLocked));
`default_nettype wire
